/* design/xbus_pkg.sv */
// shared constants and carrier types for the expansion-bus master port
package xbus_pkg;
    // bus clock divider: host clock divided by four
    localparam int unsigned clk_div_ratio = 4;
    localparam logic [1:0] clk_div_half = 2'h1;
    // hard reset hold on the bus reset output
    localparam int unsigned clk_period_ps = 8000;
    localparam int unsigned hard_reset_us = 1000;
    localparam int unsigned hard_reset_cycles = (hard_reset_us * 1000000 + clk_period_ps - 1) / clk_period_ps;
    localparam int unsigned rst_cnt_w = 18;
    // nominal cycle lengths in bus clocks
    localparam logic [3:0] len_mem16_fast = 4'h2;
    localparam logic [3:0] len_8bit_fast = 4'h3;
    localparam logic [3:0] len_mem16_norm = 4'h3;
    localparam logic [3:0] len_8bit_norm = 4'h6;
    localparam logic [3:0] len_io16_norm = 4'h3;
    localparam logic [18:0] dma_io_addr = 19'h00000;
    localparam logic [15:0] io_addr_mask = 16'hffff;
    localparam int unsigned num_cs = 2;
    localparam logic [3:0] irq15_line = 4'hf;

    typedef enum logic [1:0] {kind_mem, kind_io, kind_dma_io} cyc_kind_type;

    // one bus request from the host side
    typedef struct packed {
        cyc_kind_type kind;
        logic write;
        logic wide16;
        logic [18:0] addr;
        logic [7:0] wdata;
        logic last_count;
    } bus_req_type;

    // chip select window
    typedef struct packed {
        logic [15:0] base;
        logic [15:0] limit;
    } cs_range_type;
endpackage : xbus_pkg

/* design/xbus_clk_div.sv */
// bus reference clock divider with power-on suspend hold outside reset
`timescale 1ns/10ps
`default_nettype none
module xbus_clk_div (
    input wire logic i_clk, // host bus clock
    input wire logic i_rst_n, // sync reset, active low
    input wire logic i_suspend, // power-on suspend
    output logic o_bus_clk, // bus reference clock
    output logic o_rise // one-cycle pulse at bus clock rise
);
    // power-up value: the counter is never reset, so the bus clock keeps running through reset
    logic [1:0] cnt_q = 2'h0;
    logic [1:0] cnt_d;
    logic clk_q;
    logic clk_d;

    // next state: counter keeps running through reset
    always_comb begin
        cnt_d = cnt_q + 2'h1;
        clk_d = (cnt_d >= xbus_pkg::clk_div_half + 2'h1) && !i_suspend;
    end

    always_ff @(posedge i_clk) begin
        cnt_q <= cnt_d;
        clk_q <= i_rst_n ? clk_d : cnt_d[1];
    end

    assign o_bus_clk = clk_q;
    assign o_rise = clk_d && !clk_q;

    sequence s_clk_rise;
        $rose(clk_q);
    endsequence
    property p_div_period;
        @(posedge i_clk) disable iff (i_suspend) s_clk_rise |-> ##4 $rose(clk_q);
    endproperty
    a_div_period: assert property (p_div_period) else $error("bus clock period not four");
    property p_div_high;
        @(posedge i_clk) disable iff (i_suspend) s_clk_rise |-> ##2 !clk_q;
    endproperty
    a_div_high: assert property (p_div_high) else $error("bus clock high phase not two");
endmodule : xbus_clk_div
`default_nettype wire

/* design/xbus_master_port.sv */
// expansion-bus master port: strobes, selects, reset, terminal count
`timescale 1ns/10ps
`default_nettype none
module xbus_master_port (
    input wire logic i_clk, // host bus clock, 125 MHz
    input wire logic i_rst_n, // host reset, active low
    input wire logic i_power_good, // power good
    input wire logic i_hard_reset, // hard reset request pulse
    input wire logic i_suspend, // power-on suspend
    input wire logic i_req_valid, // bus request valid
    input wire xbus_pkg::bus_req_type i_req, // bus request
    output logic o_req_ready, // request accepted
    output logic o_done, // cycle finished pulse
    output logic [7:0] o_rdata, // read data
    input wire xbus_pkg::cs_range_type [1:0] i_cs_range, // chip select windows
    input wire logic i_irq15_serial, // serial interrupt source
    input wire logic i_irq15_pci, // pci interrupt source
    input wire logic i_irq15_steer_serial, // steer serial irq to fifteen
    input wire logic i_irq15_steer_pci, // steer pci irq to fifteen
    output logic o_irq15, // interrupt request fifteen
    output logic o_mem_write_strobe_n, // memory write strobe out
    output logic o_mem_write_strobe_oe_n, // strobe enable, low drives
    output logic o_io_read_strobe_n, // I/O read strobe out
    output logic o_io_write_strobe_n, // I/O write strobe
    output logic o_mem_read_strobe_n, // memory read strobe
    output logic [1:0] o_prog_chip_select_n, // programmable selects
    output logic o_bus_reset_out, // bus reset drive
    output logic [18:0] o_sys_addr, // system address
    output logic o_sys_addr_oe_n, // address enable, low drives
    output logic [7:0] o_sys_data, // data out
    output logic o_sys_data_oe_n, // data enable, low drives
    input wire logic [7:0] i_sys_data, // data in
    output logic o_bus_ref_clk, // bus reference clock
    output logic o_dma_last_count, // terminal count
    input wire logic i_no_wait_request_n, // zero wait request
    input wire logic i_chan_ready // channel ready
);
    typedef enum logic [1:0] {st_idle, st_run, st_end} st_type;

    logic bus_rise;
    xbus_clk_div u_div (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_suspend(i_suspend),
        .o_bus_clk(o_bus_ref_clk),
        .o_rise(bus_rise)
    );

    // synchronisers
    logic [1:0] nw_sync_q;
    logic [1:0] rdy_sync_q;
    logic [1:0] nw_sync_d;
    logic [1:0] rdy_sync_d;
    always_comb begin
        nw_sync_d = {nw_sync_q[0], i_no_wait_request_n};
        rdy_sync_d = {rdy_sync_q[0], i_chan_ready};
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            nw_sync_q <= 2'h3;
            rdy_sync_q <= 2'h3;
        end else begin
            nw_sync_q <= nw_sync_d;
            rdy_sync_q <= rdy_sync_d;
        end
    end
    wire logic nw_req = !nw_sync_q[1];
    wire logic ready = rdy_sync_q[1];

    // bus reset control
    logic [xbus_pkg::rst_cnt_w-1:0] rst_cnt_q;
    logic [xbus_pkg::rst_cnt_w-1:0] rst_cnt_d;
    logic bus_rst_q;
    logic bus_rst_d;
    always_comb begin
        rst_cnt_d = rst_cnt_q;
        if (i_hard_reset)
            rst_cnt_d = xbus_pkg::rst_cnt_w'(xbus_pkg::hard_reset_cycles);
        else if (rst_cnt_q != '0)
            rst_cnt_d = rst_cnt_q - xbus_pkg::rst_cnt_w'(1);
        bus_rst_d = !i_power_good || i_hard_reset || (rst_cnt_q != '0);
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rst_cnt_q <= '0;
            bus_rst_q <= 1'b1;
        end else begin
            rst_cnt_q <= rst_cnt_d;
            bus_rst_q <= bus_rst_d;
        end
    end
    assign o_bus_reset_out = bus_rst_q;

    // bus cycle engine, counting bus clocks
    st_type st_q;
    st_type st_d;
    xbus_pkg::bus_req_type cur_q;
    xbus_pkg::bus_req_type cur_d;
    logic [3:0] bclk_q;
    logic [3:0] bclk_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic tc_q;
    logic tc_d;
    logic done_d;
    logic done_q;

    // normal and shortened lengths per cycle type; 16-bit I/O has the normal length only
    function automatic logic [3:0] cyc_len(input xbus_pkg::bus_req_type r, input logic fast);
        if (r.kind == xbus_pkg::kind_mem && r.wide16)
            cyc_len = fast ? xbus_pkg::len_mem16_fast : xbus_pkg::len_mem16_norm;
        else if (r.wide16)
            cyc_len = xbus_pkg::len_io16_norm;
        else
            cyc_len = fast ? xbus_pkg::len_8bit_fast : xbus_pkg::len_8bit_norm;
    endfunction : cyc_len

    logic fast_ok;
    always_comb begin
        st_d = st_q;
        cur_d = cur_q;
        bclk_d = bclk_q;
        rdata_d = rdata_q;
        tc_d = tc_q;
        done_d = 1'b0;
        fast_ok = nw_req && ready && !(cur_q.kind != xbus_pkg::kind_mem && cur_q.wide16);
        case (st_q)
            st_idle: begin
                tc_d = 1'b0;
                if (i_req_valid && !bus_rst_q) begin
                    cur_d = i_req;
                    bclk_d = 4'h0;
                    st_d = st_run;
                end
            end
            st_run: begin
                if (bus_rise) begin
                    tc_d = cur_q.kind == xbus_pkg::kind_dma_io && cur_q.last_count;
                    if (ready)
                        bclk_d = bclk_q + 4'h1;
                    if (ready && (bclk_q + 4'h1 >= cyc_len(cur_q, fast_ok))) begin
                        // data still held at this edge
                        rdata_d = i_sys_data;
                        st_d = st_end;
                    end
                end
            end
            default: begin
                done_d = 1'b1;
                st_d = st_idle;
            end
        endcase
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_q <= st_idle;
            cur_q <= '0;
            bclk_q <= 4'h0;
            rdata_q <= 8'h00;
            tc_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cur_q <= cur_d;
            bclk_q <= bclk_d;
            rdata_q <= rdata_d;
            tc_q <= tc_d;
            done_q <= done_d;
        end
    end
    assign o_req_ready = (st_q == st_idle) && !bus_rst_q;
    assign o_done = done_q;
    assign o_rdata = rdata_q;
    assign o_dma_last_count = tc_q;

    // pin drive: strobes active in st_run
    wire logic run = (st_q == st_run);
    wire logic is_io = cur_q.kind != xbus_pkg::kind_mem;
    assign o_mem_write_strobe_n = !(run && !is_io && cur_q.write);
    assign o_mem_write_strobe_oe_n = !i_rst_n;
    assign o_mem_read_strobe_n = !(run && !is_io && !cur_q.write);
    assign o_io_read_strobe_n = !(run && is_io && !cur_q.write);
    assign o_io_write_strobe_n = !(run && is_io && cur_q.write);
    assign o_sys_addr = (cur_q.kind == xbus_pkg::kind_dma_io) ? xbus_pkg::dma_io_addr :
        (cur_q.kind == xbus_pkg::kind_io) ? {3'h0, cur_q.addr[15:0] & xbus_pkg::io_addr_mask} : cur_q.addr;
    assign o_sys_addr_oe_n = !i_rst_n;
    assign o_sys_data = cur_q.wdata;
    assign o_sys_data_oe_n = !(i_rst_n && run && cur_q.write);

    for (genvar g = 0; g < xbus_pkg::num_cs; g++) begin : g_cs
        assign o_prog_chip_select_n[g] = !(run && cur_q.kind == xbus_pkg::kind_io &&
            cur_q.addr[15:0] >= i_cs_range[g].base && cur_q.addr[15:0] <= i_cs_range[g].limit);
    end

    assign o_irq15 = (i_irq15_steer_serial && i_irq15_serial) || (i_irq15_steer_pci && i_irq15_pci);

    property p_rst_pg;
        @(posedge i_clk) disable iff (!i_rst_n) !i_power_good |=> o_bus_reset_out;
    endproperty
    a_rst_pg: assert property (p_rst_pg) else $error("bus reset not held without power good");
    property p_hard_rst;
        @(posedge i_clk) disable iff (!i_rst_n) i_hard_reset |=> o_bus_reset_out [*8];
    endproperty
    a_hard_rst: assert property (p_hard_rst) else $error("hard reset hold too short");
    property p_dma_zero;
        @(posedge i_clk) disable iff (!i_rst_n) run && cur_q.kind == xbus_pkg::kind_dma_io |-> o_sys_addr == '0;
    endproperty
    a_dma_zero: assert property (p_dma_zero) else $error("dma io address not zero");
    property p_tc_idle;
        @(posedge i_clk) disable iff (!i_rst_n) st_q == st_idle |=> !o_dma_last_count;
    endproperty
    a_tc_idle: assert property (p_tc_idle) else $error("terminal count high while idle");
    property p_cs_io;
        @(posedge i_clk) disable iff (!i_rst_n)
            o_prog_chip_select_n != 2'h3 |-> !o_io_read_strobe_n || !o_io_write_strobe_n;
    endproperty
    a_cs_io: assert property (p_cs_io) else $error("chip select outside io cycle");
    property p_mem_write_strobe_n_idle;
        @(posedge i_clk) disable iff (!i_rst_n) st_q == st_idle |-> o_mem_write_strobe_n;
    endproperty
    a_mem_write_strobe_n_idle: assert property (p_mem_write_strobe_n_idle) else $error("write strobe low while idle");
    property p_data_rel;
        @(posedge i_clk) !i_rst_n |-> o_sys_data_oe_n && o_sys_addr_oe_n;
    endproperty
    a_data_rel: assert property (p_data_rel) else $error("bus driven in reset");
    property p_io_hi;
        @(posedge i_clk) disable iff (!i_rst_n) run && cur_q.kind == xbus_pkg::kind_io |-> o_sys_addr[18:16] == 3'h0;
    endproperty
    a_io_hi: assert property (p_io_hi) else $error("io address uses upper lines");
    // terminal count belongs to dma cycles only
    property p_tc_dma;
        @(posedge i_clk) disable iff (!i_rst_n) o_dma_last_count |-> cur_q.kind == xbus_pkg::kind_dma_io;
    endproperty
    a_tc_dma: assert property (p_tc_dma) else $error("terminal count outside dma cycle");
endmodule : xbus_master_port
`default_nettype wire

/* test/xbus_slave_model.sv */
// behavioural expansion-bus slave: read data, no-wait and channel waits
`timescale 1ns/10ps
`default_nettype none
module xbus_slave_model (
    input wire logic i_clk, // host clock
    input wire logic i_cmd_n, // any strobe, active low
    input wire logic i_rd_n, // read strobe, active low
    input wire logic [18:0] i_addr, // system address
    input wire logic i_fast, // answer with no-wait
    input wire logic [7:0] i_waits, // host cycles not ready
    output logic o_no_wait_n, // no-wait request
    output logic o_ready, // channel ready
    output logic [7:0] o_data, // read data
    output logic o_dma_req // pending dma request
);
    logic dma_req_q = 1'b1;
    // memory and I/O answers come from the far slave
    xbus_far_slave xbus_far_slave_i (.i_clk(i_clk), .i_cmd_n(i_cmd_n), .i_rd_n(i_rd_n), .i_addr(i_addr),
        .i_fast(i_fast), .i_waits(i_waits), .o_no_wait_n(o_no_wait_n), .o_ready(o_ready), .o_data(o_data));
    // request held until granted
    // no acknowledge pin here, so a strobed cycle at address zero stands for the grant
    always @(posedge i_clk) begin
        if (!i_cmd_n && i_addr == 19'h00000) begin
            dma_req_q <= 1'b0;
        end
    end
    assign o_dma_req = dma_req_q;
endmodule : xbus_slave_model
`default_nettype wire

/* test/xbus_far_slave.sv */
// far-side slave used by the bench: read data, no-wait and channel waits
`timescale 1ns/10ps
`default_nettype none
module xbus_far_slave (
    input wire logic i_clk, // host clock
    input wire logic i_cmd_n, // any strobe, active low
    input wire logic i_rd_n, // read strobe, active low
    input wire logic [18:0] i_addr, // system address
    input wire logic i_fast, // answer with no-wait
    input wire logic [7:0] i_waits, // host cycles not ready
    output logic o_no_wait_n, // no-wait request
    output logic o_ready, // channel ready
    output logic [7:0] o_data // read data
);
    logic act_q = 1'b0;
    logic [7:0] cnt_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    logic [1:0] hold_q = 2'h0;
    // decode time and read hold
    always @(posedge i_clk) begin
        act_q <= !i_cmd_n;
        cnt_q <= i_cmd_n ? 8'h00 : cnt_q + 8'h01;
        last_q <= i_rd_n ? last_q : i_addr[7:0] ^ 8'h5a;
        hold_q <= !i_rd_n ? 2'h2 : (hold_q != 2'h0 ? hold_q - 2'h1 : 2'h0);
    end
    // no-wait only after decode, and only while stalling if waits asked
    assign o_no_wait_n = !(act_q && i_fast && cnt_q != 8'h00 && (i_waits == 8'h00 || cnt_q < i_waits));
    // channel ready low for the asked waits
    assign o_ready = !(act_q && cnt_q < i_waits);
    // data held past strobe, inverse once released
    assign o_data = !i_rd_n ? i_addr[7:0] ^ 8'h5a : (hold_q != 2'h0 ? last_q : ~last_q);
endmodule : xbus_far_slave
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the expansion-bus master port
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp %h got %h", nm, e, s); end end
module tb;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_power_good = 1'b0;
    logic i_hard_reset = 1'b0;
    logic i_suspend = 1'b0;
    logic i_req_valid = 1'b0;
    logic i_irq15_serial = 1'b0, i_irq15_pci = 1'b0, i_irq15_steer_serial = 1'b0, i_irq15_steer_pci = 1'b0;
    logic i_fast = 1'b0;
    logic [7:0] i_waits = 8'h00;
    xbus_pkg::bus_req_type i_req = '0;
    xbus_pkg::bus_req_type rq;
    xbus_pkg::cs_range_type [1:0] i_cs_range = {16'h0400, 16'h04ff, 16'h0300, 16'h030f};
    logic o_req_ready, o_done, o_irq15, o_mem_write_strobe_n, o_mem_write_strobe_oe_n, o_io_read_strobe_n;
    logic o_io_write_strobe_n, o_mem_read_strobe_n, o_bus_reset_out, o_sys_addr_oe_n, o_sys_data_oe_n;
    logic o_bus_ref_clk, o_dma_last_count, i_no_wait_request_n, i_chan_ready, dma, dma_req;
    logic [1:0] o_prog_chip_select_n;
    logic [7:0] o_rdata, o_sys_data, i_sys_data;
    logic [18:0] o_sys_addr;
    logic [3:0] stb;
    logic [15:0] edges [6] = '{16'h0300, 16'h030f, 16'h0310, 16'h02ff, 16'h0400, 16'h04ff};
    logic [31:0] seed = 32'h4d3aa5a1;
    int compares = 0, miscompares = 0, cyc = 0, cnt = 0;
    assign stb = {o_mem_write_strobe_n, o_mem_read_strobe_n, o_io_write_strobe_n, o_io_read_strobe_n};
    xbus_master_port xbus_master_port_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_power_good(i_power_good),
        .i_hard_reset(i_hard_reset), .i_suspend(i_suspend), .i_req_valid(i_req_valid), .i_req(i_req),
        .o_req_ready(o_req_ready), .o_done(o_done), .o_rdata(o_rdata), .i_cs_range(i_cs_range),
        .i_irq15_serial(i_irq15_serial), .i_irq15_pci(i_irq15_pci), .i_irq15_steer_serial(i_irq15_steer_serial),
        .i_irq15_steer_pci(i_irq15_steer_pci), .o_irq15(o_irq15), .o_mem_write_strobe_n(o_mem_write_strobe_n),
        .o_mem_write_strobe_oe_n(o_mem_write_strobe_oe_n), .o_io_read_strobe_n(o_io_read_strobe_n),
        .o_io_write_strobe_n(o_io_write_strobe_n), .o_mem_read_strobe_n(o_mem_read_strobe_n),
        .o_prog_chip_select_n(o_prog_chip_select_n), .o_bus_reset_out(o_bus_reset_out), .o_sys_addr(o_sys_addr),
        .o_sys_addr_oe_n(o_sys_addr_oe_n), .o_sys_data(o_sys_data), .o_sys_data_oe_n(o_sys_data_oe_n),
        .i_sys_data(i_sys_data), .o_bus_ref_clk(o_bus_ref_clk), .o_dma_last_count(o_dma_last_count),
        .i_no_wait_request_n(i_no_wait_request_n), .i_chan_ready(i_chan_ready));
    xbus_slave_model xbus_slave_model_i (.i_clk(i_clk), .i_cmd_n(&stb), .i_rd_n(stb[2] & stb[0]),
        .i_addr(o_sys_addr), .i_fast(i_fast), .i_waits(i_waits), .o_no_wait_n(i_no_wait_request_n),
        .o_ready(i_chan_ready), .o_data(i_sys_data), .o_dma_req(dma_req));
    initial forever #4 i_clk = ~i_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // normal or shortened length in bus clocks
    function automatic int exp_len(input xbus_pkg::bus_req_type r, input logic f);
        if (r.kind == xbus_pkg::kind_mem && r.wide16) return f ? xbus_pkg::len_mem16_fast : xbus_pkg::len_mem16_norm;
        if (r.kind == xbus_pkg::kind_io && r.wide16) return xbus_pkg::len_io16_norm;
        return f ? xbus_pkg::len_8bit_fast : xbus_pkg::len_8bit_norm;
    endfunction : exp_len
    function automatic logic [1:0] exp_cs(input xbus_pkg::bus_req_type r);
        for (int k = 0; k < 2; k++) exp_cs[k] = !(r.kind == xbus_pkg::kind_io &&
            r.addr[15:0] >= i_cs_range[k].base && r.addr[15:0] <= i_cs_range[k].limit);
    endfunction : exp_cs
    task automatic step(input int n);
        repeat (n) begin
            @(posedge i_clk);
            #1;
        end
    endtask : step
    // one bus cycle; snapshot taken at the first strobe
    task automatic run_cyc(input xbus_pkg::bus_req_type r, input logic f, input logic [7:0] w);
        int n = 0, rises = 0, lo = 0;
        logic pc = 1'b0, seen = 1'b0, stc = 1'b0, soe, sdoe;
        logic [18:0] sa;
        logic [1:0] scs;
        logic [3:0] sst;
        logic [7:0] sd;
        i_fast = f;
        i_waits = w;
        for (n = 0; n < 300 && o_req_ready !== 1'b1; n++) step(1);
        `CHK("ready", 1'b1, o_req_ready)
        i_req = r;
        i_req_valid = 1'b1;
        step(1);
        i_req_valid = 1'b0;
        for (n = 0; n < 400 && o_done !== 1'b1; n++) begin
            rises += int'(o_bus_ref_clk && !pc);
            pc = o_bus_ref_clk;
            stc |= o_dma_last_count;
            if (!seen && stb != 4'hf) begin
                {seen, sst, sa, scs, soe, sdoe, sd} = {1'b1, stb, o_sys_addr, o_prog_chip_select_n,
                    o_sys_addr_oe_n, o_sys_data_oe_n, o_sys_data};
            end
            step(1);
        end
        `CHK("done", 1'b1, o_done)
        lo = exp_len(r, f && w == 8'h00) + (w != 8'h00 ? 2 : 0);
        `CHK("len", 1'b1, rises >= lo && rises <= lo + (w != 8'h00 ? 6 : 2))
        `CHK("tc", r.kind == xbus_pkg::kind_dma_io && r.last_count, stc)
        `CHK("addr_oe", 1'b0, soe)
        `CHK("cs", exp_cs(r), scs)
        if (r.kind == xbus_pkg::kind_dma_io) `CHK("addr", 19'h00000, sa)
        else if (r.kind == xbus_pkg::kind_io) `CHK("addr", r.addr[15:0], sa[15:0])
        else `CHK("addr", r.addr, sa)
        if (r.kind != xbus_pkg::kind_dma_io) begin
            `CHK("strobe", r.kind == xbus_pkg::kind_mem ? (r.write ? 4'h7 : 4'hb) : (r.write ? 4'hd : 4'he), sst)
            `CHK("data_oe", !r.write, sdoe)
            if (r.write) `CHK("wdata", r.wdata, sd)
            else `CHK("rdata", r.addr[7:0] ^ 8'h5a, o_rdata)
        end
    endtask : run_cyc
    task wrap_up;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    // hang guard, far above the expected run
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        step(4);
        for (int k = 0; k < 8; k++) begin
            cnt += int'(o_bus_ref_clk == 1'b0);
            step(1);
        end
        `CHK("clk_div", 4, cnt)
        `CHK("rst_out", 1'b1, o_bus_reset_out)
        `CHK("wr_oe", 1'b1, o_mem_write_strobe_oe_n)
        `CHK("data_oe", 1'b1, o_sys_data_oe_n)
        `CHK("tc", 1'b0, o_dma_last_count)
        `CHK("addr_oe", 1'b1, o_sys_addr_oe_n)
        step(4);
        i_rst_n = 1'b1;
        step(20);
        `CHK("rst_out", 1'b1, o_bus_reset_out)
        `CHK("wr_idle", 1'b1, o_mem_write_strobe_n)
        `CHK("wr_oe", 1'b0, o_mem_write_strobe_oe_n)
        i_power_good = 1'b1;
        step(8);
        `CHK("rst_out", 1'b0, o_bus_reset_out)
        `CHK("dma_req", 1'b1, dma_req)
        // every kind at window edges, with every direction, width and speed for memory and I/O; then random cycles
        for (int c = 0; c < 64; c++) begin
            seed = lfsr(seed);
            rq.kind = xbus_pkg::cyc_kind_type'(c < 24 ? c % 3 : (seed[1:0] == 2'h3 ? 0 : int'(seed[1:0])));
            dma = rq.kind == xbus_pkg::kind_dma_io;
            rq.write = (c < 24 ? c / 3 % 2 == 1 : seed[2]) && !dma;
            rq.wide16 = (c < 24 ? c / 6 % 2 == 1 : seed[3]) && !dma;
            rq.addr = c < 24 ? {c[2:0], edges[c % 6]} : seed[26:8];
            rq.wdata = seed[31:24];
            rq.last_count = seed[4];
            run_cyc(rq, (c < 24 ? c >= 12 : seed[5]) && !dma, c >= 24 && seed[7:6] == 2'h0 ? 8'h10 : 8'h00);
        end
        `CHK("dma_req", 1'b0, dma_req)
        for (int c = 0; c < 16; c++) begin
            {i_irq15_serial, i_irq15_pci, i_irq15_steer_serial, i_irq15_steer_pci} = c[3:0];
            step(1);
            `CHK("irq15", (c[3] & c[1]) | (c[2] & c[0]), o_irq15)
        end
        i_suspend = 1'b1;
        step(4);
        cnt = 0;
        for (int k = 0; k < 8; k++) begin
            cnt += int'(o_bus_ref_clk);
            step(1);
        end
        `CHK("clk_susp", 0, cnt)
        i_suspend = 1'b0;
        i_hard_reset = 1'b1;
        step(1);
        i_hard_reset = 1'b0;
        step(2000);
        `CHK("hard_rst", 1'b1, o_bus_reset_out)
        wrap_up();
    end
endmodule : tb
`default_nettype wire
